// >>> src/stcb_pkg.sv
// Operation
// RULE1 - level seven value is read/write at bits 19..10, bit 10 least significant
// RULE2 - level six value is read/write at bits 9..0, bit 0 least significant
// RULE3 - level nine value sits at bits 19..10 of offset 0x2D
// RULE4 - level eight value sits at bits 9..0 of offset 0x2D
// RULE5 - a 3-bit select code n picks level n; levels eight, nine unreachable
// RULE6 - offset 0x2E holds selects for inputs 0..7, three bits each, reset zero
// RULE7 - offset 0x2F holds inputs 8..11 and group two A/B; bits 23..18 reserved
// RULE8 - offset 0x30 holds group three A/B/C, sense A/B; top three bits reserved
// RULE9 - reserved upper bits of level value words read zero, ignore writes
// RULE10 - 2-bit event code: none, rising, falling, or both crossings
// RULE11 - per-input mode bit: 0 comparator, 1 converter evaluation
// RULE12 - each input level is compared with its selected stored level
package stcb_pkg;
   localparam int unsigned STCB_ADDR_W   = 6;
   localparam int unsigned STCB_DATA_W   = 24;
   localparam int unsigned STCB_LEVEL_W  = 10;
   localparam int unsigned STCB_SEL_W    = 3;
   localparam int unsigned STCB_INPUTS   = 24;
   localparam int unsigned STCB_CHANNELS = 26;
   localparam int unsigned STCB_LOW_LVLS = 6;

   localparam logic [5:0] OFS_LEVEL_SIX_SEVEN  = 6'h2C;
   localparam logic [5:0] OFS_LEVEL_EIGHT_NINE = 6'h2D;
   localparam logic [5:0] OFS_LOW_INPUTS_MAP   = 6'h2E;
   localparam logic [5:0] OFS_MID_INPUTS_MAP   = 6'h2F;
   localparam logic [5:0] OFS_HIGH_SENSE_MAP   = 6'h30;

   // writable bits of each word; everything else reads zero
   localparam logic [23:0] MASK_LEVEL_WORD = 24'h0FFFFF;
   localparam logic [23:0] MASK_LOW_MAP    = 24'hFFFFFF;
   localparam logic [23:0] MASK_MID_MAP    = 24'h03FFFF;
   localparam logic [23:0] MASK_HIGH_MAP   = 24'h1FFFFF;

   localparam logic [23:0] RST_LEVEL_WORD = 24'h000000;
   localparam logic [23:0] RST_MAP_WORD   = 24'h000000;

   localparam int unsigned POS_UPPER_LEVEL = 10;
   localparam int unsigned POS_LOWER_LEVEL = 0;
   localparam int unsigned POS_GROUP2_A    = 12;
   localparam int unsigned POS_GROUP2_B    = 15;
   localparam int unsigned POS_GROUP3_A    = 0;
   localparam int unsigned POS_GROUP3_B    = 3;
   localparam int unsigned POS_GROUP3_C    = 6;
   localparam int unsigned POS_SENSE0_A    = 9;
   localparam int unsigned POS_SENSE1_B    = 18;

   localparam logic [1:0] EVT_NONE    = 2'h0;
   localparam logic [1:0] EVT_RISING  = 2'h1;
   localparam logic [1:0] EVT_FALLING = 2'h2;
   localparam logic [1:0] EVT_BOTH    = 2'h3;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  addr;
      logic [23:0] wdata;
   } stcb_req_t;

   typedef struct packed {
      logic       above;
      logic       rise_evt;
      logic       fall_evt;
      logic [9:0] conv_level;
   } stcb_chan_t;
endpackage : stcb_pkg

// >>> src/stcb_channel.sv
`timescale 1ns/1ps
module stcb_channel
   import stcb_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // evaluation inputs
   input  wire logic [STCB_LEVEL_W-1:0] level,
   input  wire logic [STCB_LEVEL_W-1:0] threshold,
   input  wire logic                    eval_kind,
   input  wire logic [1:0]              evt_ctl,
   // result
   output stcb_chan_t                   result
);
   logic above_nxt;
   stcb_chan_t res_r;

   assign above_nxt = (level > threshold); // RULE12
   assign result    = res_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_r.above    <= 1'b0;
         res_r.rise_evt <= 1'b0;
         res_r.fall_evt <= 1'b0;
      end else begin
         res_r.above    <= above_nxt; // RULE12
         res_r.rise_evt <= above_nxt & ~res_r.above & evt_ctl[0]; // RULE10
         res_r.fall_evt <= ~above_nxt & res_r.above & evt_ctl[1]; // RULE10
      end
   end

   // converter mode also reports the raw code; comparator mode holds zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_r.conv_level <= '0;
      end else begin
         res_r.conv_level <= eval_kind ? level : '0; // RULE11
      end
   end
endmodule : stcb_channel

// >>> src/stcb_bank.sv
`timescale 1ns/1ps
module stcb_bank
   import stcb_pkg::*;
(
   // clock and reset
   input  wire logic                                        clk,
   input  wire logic                                        rst_n,
   // register port
   input  stcb_req_t                                        req,
   output logic [STCB_DATA_W-1:0]                           rd_data_r,
   output logic                                             rd_valid_r,
   // levels zero to five, held elsewhere
   input  wire logic [STCB_LOW_LVLS-1:0][STCB_LEVEL_W-1:0]  low_levels,
   // sampled channel levels: inputs 0..23, sense 0, sense 1
   input  wire logic [STCB_CHANNELS-1:0][STCB_LEVEL_W-1:0]  chan_level,
   input  wire logic [STCB_CHANNELS-1:0]                    chan_eval_kind,
   input  wire logic [STCB_CHANNELS-1:0][1:0]               chan_evt_ctl,
   // results
   output stcb_chan_t [STCB_CHANNELS-1:0]                   chan_result
);
   logic rst_sync1_r;
   logic rst_sync2_r;
   logic rst_n_int;

   logic [23:0] lvl67_r;
   logic [23:0] lvl89_r;
   logic [23:0] map_low_r;
   logic [23:0] map_mid_r;
   logic [23:0] map_high_r;
   logic [23:0] rd_data_nxt;

   logic [STCB_CHANNELS-1:0][STCB_LEVEL_W-1:0] chan_thr;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end
   assign rst_n_int = rst_sync2_r;

   function automatic logic [23:0] merge_word(input logic [23:0] old_v, input logic [23:0] new_v,
                                              input logic [23:0] mask);
      merge_word = (old_v & ~mask) | (new_v & mask);
   endfunction : merge_word

   function automatic logic hit(input stcb_req_t r, input logic [5:0] ofs);
      hit = (r.addr == ofs);
   endfunction : hit

   // select code n picks level n; eight and nine cannot be chosen
   // registers come in as arguments so a continuous assignment re-evaluates when they change
   function automatic logic [9:0] pick_level(input logic [2:0] sel, input logic [23:0] lv67,
                                             input logic [STCB_LOW_LVLS-1:0][STCB_LEVEL_W-1:0] low);
      logic [9:0] v;
      v = '0;
      if (sel < 3'h6) begin
         v = low[sel];
      end else if (sel == 3'h6) begin
         v = lv67[POS_LOWER_LEVEL +: STCB_LEVEL_W];
      end else begin
         v = lv67[POS_UPPER_LEVEL +: STCB_LEVEL_W];
      end
      pick_level = v; // RULE5
   endfunction : pick_level

   function automatic logic [2:0] chan_sel(input int unsigned ch, input logic [23:0] lo,
                                           input logic [23:0] mid, input logic [23:0] hi);
      logic [2:0] s;
      s = '0;
      if (ch < 8) begin
         s = lo[ch*3 +: 3]; // RULE6
      end else if (ch < 12) begin
         s = mid[(ch-8)*3 +: 3]; // RULE7
      end else if (ch < 18) begin
         s = mid[POS_GROUP2_A +: 3]; // RULE7
      end else if (ch < 24) begin
         s = hi[POS_GROUP3_A +: 3]; // RULE8
      end else if (ch == 24) begin
         s = hi[POS_SENSE0_A +: 3]; // RULE8
      end else begin
         s = hi[POS_SENSE1_B +: 3]; // RULE8
      end
      chan_sel = s;
   endfunction : chan_sel

   // level values: reserved bits masked off on write
   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         lvl67_r <= RST_LEVEL_WORD;
      end else if (req.wr && hit(req, OFS_LEVEL_SIX_SEVEN)) begin
         lvl67_r <= merge_word(lvl67_r, req.wdata, MASK_LEVEL_WORD); // RULE1 RULE2 RULE9
      end
   end

   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         lvl89_r <= RST_LEVEL_WORD;
      end else if (req.wr && hit(req, OFS_LEVEL_EIGHT_NINE)) begin
         lvl89_r <= merge_word(lvl89_r, req.wdata, MASK_LEVEL_WORD); // RULE3 RULE4 RULE9
      end
   end

   // selector maps
   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         map_low_r <= RST_MAP_WORD;
      end else if (req.wr && hit(req, OFS_LOW_INPUTS_MAP)) begin
         map_low_r <= merge_word(map_low_r, req.wdata, MASK_LOW_MAP); // RULE6
      end
   end

   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         map_mid_r <= RST_MAP_WORD;
      end else if (req.wr && hit(req, OFS_MID_INPUTS_MAP)) begin
         map_mid_r <= merge_word(map_mid_r, req.wdata, MASK_MID_MAP); // RULE7
      end
   end

   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         map_high_r <= RST_MAP_WORD;
      end else if (req.wr && hit(req, OFS_HIGH_SENSE_MAP)) begin
         map_high_r <= merge_word(map_high_r, req.wdata, MASK_HIGH_MAP); // RULE8
      end
   end

   // read decode; unmapped offsets return zero
   always_comb begin
      rd_data_nxt = '0;
      if (hit(req, OFS_LEVEL_SIX_SEVEN)) begin
         rd_data_nxt = lvl67_r & MASK_LEVEL_WORD; // RULE9
      end else if (hit(req, OFS_LEVEL_EIGHT_NINE)) begin
         rd_data_nxt = lvl89_r & MASK_LEVEL_WORD; // RULE9
      end else if (hit(req, OFS_LOW_INPUTS_MAP)) begin
         rd_data_nxt = map_low_r;
      end else if (hit(req, OFS_MID_INPUTS_MAP)) begin
         rd_data_nxt = map_mid_r & MASK_MID_MAP;
      end else if (hit(req, OFS_HIGH_SENSE_MAP)) begin
         rd_data_nxt = map_high_r & MASK_HIGH_MAP;
      end
   end

   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         rd_data_r  <= '0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= req.rd;
         if (req.rd) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   // per-channel evaluation against the currently stored map
   for (genvar g = 0; g < STCB_CHANNELS; g++) begin : g_chan
      assign chan_thr[g] = pick_level(chan_sel(g, map_low_r, map_mid_r, map_high_r), lvl67_r, low_levels); // RULE12
      stcb_channel u_chan (
         .clk       (clk),
         .rst_n     (rst_n_int),
         .level     (chan_level[g]),
         .threshold (chan_thr[g]),
         .eval_kind (chan_eval_kind[g]),
         .evt_ctl   (chan_evt_ctl[g]),
         .result    (chan_result[g])
      );
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_int);

   sequence wr_at(logic [5:0] ofs);
      req.wr && req.addr == ofs;
   endsequence

   sequence crossed_up;
      chan_result[0].above && !$past(chan_result[0].above);
   endsequence

   sequence crossed_down;
      !chan_result[0].above && $past(chan_result[0].above);
   endsequence

   sequence rd_at(logic [5:0] ofs);
      req.rd && req.addr == ofs;
   endsequence

   level_seven_a: assert property (wr_at(OFS_LEVEL_SIX_SEVEN) |=> // RULE1
      lvl67_r[19:10] == $past(req.wdata[19:10]))
      else $error("level seven not stored");
   level_six_a: assert property (wr_at(OFS_LEVEL_SIX_SEVEN) |=> // RULE2
      lvl67_r[9:0] == $past(req.wdata[9:0]))
      else $error("level six not stored");
   level_nine_a: assert property (wr_at(OFS_LEVEL_EIGHT_NINE) |=> // RULE3
      lvl89_r[19:10] == $past(req.wdata[19:10]))
      else $error("level nine not stored");
   level_eight_a: assert property (wr_at(OFS_LEVEL_EIGHT_NINE) |=> // RULE4
      lvl89_r[9:0] == $past(req.wdata[9:0]))
      else $error("level eight not stored");
   select_seven_a: assert property (map_low_r[2:0] == 3'h7 |-> // RULE5
      chan_thr[0] == lvl67_r[19:10])
      else $error("select code seven picked wrong level");
   low_map_a: assert property (wr_at(OFS_LOW_INPUTS_MAP) |=> // RULE6
      map_low_r == $past(req.wdata))
      else $error("low input map not stored");
   mid_reserved_a: assert property (req.rd && req.addr == OFS_MID_INPUTS_MAP |=> // RULE7
      rd_valid_r && rd_data_r[23:18] == 6'h00 && rd_data_r[17:0] == $past(map_mid_r[17:0]))
      else $error("mid map readback wrong");
   high_reserved_a: assert property (wr_at(OFS_HIGH_SENSE_MAP) |=> // RULE8
      map_high_r[23:21] == 3'h0 && map_high_r[20:0] == $past(req.wdata[20:0]))
      else $error("high map reserved bits written");
   level_reserved_a: assert property (req.rd && req.addr == OFS_LEVEL_EIGHT_NINE |=> // RULE9
      rd_data_r[23:20] == 4'h0 && rd_data_r[19:0] == $past(lvl89_r[19:0]))
      else $error("level word reserved bits nonzero");
   rise_event_a: assert property (crossed_up ##0 $past(chan_evt_ctl[0][0]) |-> // RULE10
      chan_result[0].rise_evt)
      else $error("rising crossing event missed");
   no_event_a: assert property ($past(chan_evt_ctl[0]) == EVT_NONE |-> // RULE10
      !chan_result[0].rise_evt && !chan_result[0].fall_evt)
      else $error("event raised with events off");
   conv_level_a: assert property ($past(chan_eval_kind[0]) |-> // RULE11
      chan_result[0].conv_level == $past(chan_level[0]))
      else $error("converter level not reported");
   compare_a: assert property (chan_result[0].above == $past(chan_level[0] > chan_thr[0])) // RULE12
      else $error("comparison against selected level wrong");
   fall_event_a: assert property (crossed_down ##0 $past(chan_evt_ctl[0][1]) |-> // RULE10
      chan_result[0].fall_evt)
      else $error("falling crossing event missed");
   rise_cause_a: assert property (chan_result[0].rise_evt |-> // RULE10
      crossed_up ##0 $past(chan_evt_ctl[0][0]))
      else $error("rising event without enabled crossing");
   fall_cause_a: assert property (chan_result[0].fall_evt |-> // RULE10
      crossed_down ##0 $past(chan_evt_ctl[0][1]))
      else $error("falling event without enabled crossing");
   comp_zero_a: assert property (!$past(chan_eval_kind[0]) |-> // RULE11
      chan_result[0].conv_level == 10'h000)
      else $error("comparator mode reported a level");
   at_level_a: assert property ($past(chan_level[0] == chan_thr[0]) |-> // RULE12
      !chan_result[0].above)
      else $error("level equal to threshold counted as above");
   select_six_a: assert property (map_low_r[2:0] == 3'h6 |-> // RULE5
      chan_thr[0] == lvl67_r[9:0])
      else $error("select code six picked wrong level");
   select_low_a: assert property (map_low_r[2:0] < 3'h6 |-> // RULE5
      chan_thr[0] == low_levels[map_low_r[2:0]])
      else $error("low select code picked wrong level");
   input_seven_a: assert property (map_low_r[23:21] == map_low_r[2:0] |-> // RULE6
      chan_thr[7] == chan_thr[0])
      else $error("input seven select field misplaced");
   input_eight_a: assert property (map_mid_r[2:0] == map_low_r[2:0] |-> // RULE7
      chan_thr[8] == chan_thr[0])
      else $error("input eight select field misplaced");
   group_two_a: assert property (map_mid_r[14:12] == map_low_r[2:0] |-> // RULE7
      chan_thr[12] == chan_thr[0] && chan_thr[17] == chan_thr[0])
      else $error("group two shared select misplaced");
   group_three_a: assert property (map_high_r[2:0] == map_low_r[2:0] |-> // RULE8
      chan_thr[18] == chan_thr[0] && chan_thr[23] == chan_thr[0])
      else $error("group three shared select misplaced");
   sense_zero_a: assert property (map_high_r[11:9] == map_low_r[2:0] |-> // RULE8
      chan_thr[24] == chan_thr[0])
      else $error("sense zero select misplaced");
   sense_one_a: assert property (map_high_r[20:18] == map_low_r[2:0] |-> // RULE8
      chan_thr[25] == chan_thr[0])
      else $error("sense one select misplaced");
   mid_write_a: assert property (wr_at(OFS_MID_INPUTS_MAP) |=> // RULE7
      map_mid_r[23:18] == 6'h00 && map_mid_r[17:0] == $past(req.wdata[17:0]))
      else $error("mid map write wrong");
   six_seven_read_a: assert property (rd_at(OFS_LEVEL_SIX_SEVEN) |=> // RULE9
      rd_valid_r && rd_data_r == {4'h0, $past(lvl67_r[19:0])})
      else $error("level six seven readback wrong");
   low_map_read_a: assert property (rd_at(OFS_LOW_INPUTS_MAP) |=> // RULE6
      rd_valid_r && rd_data_r == $past(map_low_r))
      else $error("low map readback wrong");
   high_map_read_a: assert property (rd_at(OFS_HIGH_SENSE_MAP) |=> // RULE8
      rd_valid_r && rd_data_r == {3'h0, $past(map_high_r[20:0])})
      else $error("high map readback wrong");
   upper_zero_a: assert property (lvl67_r[23:20] == 4'h0 && // RULE9
      lvl89_r[23:20] == 4'h0)
      else $error("reserved level bits hold ones");
   six_seven_hold_a: assert property (!(req.wr && req.addr == OFS_LEVEL_SIX_SEVEN) |=> // RULE1
      $stable(lvl67_r))
      else $error("level six seven changed without write");
   eight_nine_hold_a: assert property (!(req.wr && req.addr == OFS_LEVEL_EIGHT_NINE) |=> // RULE3
      $stable(lvl89_r))
      else $error("level eight nine changed without write");
   low_hold_a: assert property (!(req.wr && req.addr == OFS_LOW_INPUTS_MAP) |=> // RULE6
      $stable(map_low_r))
      else $error("low map changed without write");
   mid_hold_a: assert property (!(req.wr && req.addr == OFS_MID_INPUTS_MAP) |=> // RULE7
      $stable(map_mid_r))
      else $error("mid map changed without write");
   high_hold_a: assert property (!(req.wr && req.addr == OFS_HIGH_SENSE_MAP) |=> // RULE8
      $stable(map_high_r))
      else $error("high map changed without write");
endmodule : stcb_bank

// >>> sim/stcb_host.sv
`timescale 1ns/1ps
module stcb_host
   import stcb_pkg::*;
(
   // clock
   input  wire logic        clk,
   // register request
   output stcb_req_t        req,
   // read answer
   input  wire logic [23:0] rd_data_r,
   input  wire logic        rd_valid_r
);
   initial req = '0;

   // idle cycles carry inverted address, and inverted data after a write, so stale values never match
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: req.wdata};
      #1;
      d = rd_data_r;
      v = rd_valid_r;
   endtask : rd
endmodule : stcb_host

// >>> sim/switch_threshold_config_bank_tb.sv
`timescale 1ns/1ps
module switch_threshold_config_bank_tb
   import stcb_pkg::*;
;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   stcb_req_t        req;
   logic [23:0]      rd_data;
   logic             rd_valid;
   logic [5:0][9:0]  low_lv = '0;
   logic [25:0][9:0] lvl = '0;
   logic [25:0]      kind = '0;
   logic [25:0][1:0] evt = '0;
   stcb_chan_t [25:0] res;
   logic [23:0]      sh[5] = '{default: '0};
   logic [31:0]      seed = 32'h61C8;
   int               n_fail = 0;
   int               n_tests = 0;

   always #12.5 clk = ~clk;

   stcb_bank dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rd_data_r(rd_data), .rd_valid_r(rd_valid),
      .low_levels(low_lv), .chan_level(lvl), .chan_eval_kind(kind), .chan_evt_ctl(evt), .chan_result(res));
   stcb_host host_u (.clk(clk), .req(req), .rd_data_r(rd_data), .rd_valid_r(rd_valid));

   function automatic logic [31:0] nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : nxt

   function automatic logic [23:0] msk(input logic [5:0] a);
      case (a)
         6'h2C, 6'h2D: msk = 24'h0FFFFF;
         6'h2E:        msk = 24'hFFFFFF;
         6'h2F:        msk = 24'h03FFFF;
         6'h30:        msk = 24'h1FFFFF;
         default:      msk = 24'h000000;
      endcase
   endfunction : msk

   // level picked by the select code of one channel
   function automatic logic [9:0] thr(input int ch);
      logic [2:0] s;
      if (ch < 8) s = sh[2][3*ch+:3];
      else if (ch < 12) s = sh[3][3*(ch-8)+:3];
      else if (ch < 18) s = sh[3][14:12];
      else if (ch < 24) s = sh[4][2:0];
      else if (ch == 24) s = sh[4][11:9];
      else s = sh[4][20:18];
      return (s < 6) ? low_lv[s] : (s == 6) ? sh[0][9:0] : sh[0][19:10];
   endfunction : thr

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic readback();
      logic [23:0] d;
      logic        v;
      for (int a = 'h2B; a <= 'h31; a++) begin
         host_u.rd(6'(a), d, v);
         chk("word", {1'b1, (msk(6'(a)) != 0) ? sh[a-'h2C] : 24'h0}, {v, d});
      end
   endtask : readback

   task automatic trial();
      logic [9:0] a[26];
      logic [9:0] b[26];
      logic [9:0] t;
      @(posedge clk);
      for (int i = 0; i < 26; i++) begin
         lvl[i] <= 10'(nxt());
         kind[i] <= 1'(nxt());
         evt[i] <= 2'(nxt());
      end
      for (int i = 0; i < 6; i++) low_lv[i] <= 10'(nxt());
      repeat (2) @(posedge clk);
      // every fourth channel sits exactly on its level
      for (int i = 0; i < 26; i++) begin
         a[i] = lvl[i];
         b[i] = (i % 4 == 0) ? thr(i) : 10'(nxt());
         lvl[i] <= b[i];
      end
      @(posedge clk);
      #1;
      for (int i = 0; i < 26; i++) begin
         t = thr(i);
         chk("above", b[i] > t, res[i].above);
         chk("conv", kind[i] ? b[i] : 10'h0, res[i].conv_level);
         if (!kind[i]) begin
            chk("rise", evt[i][0] & (b[i] > t) & !(a[i] > t), res[i].rise_evt);
            chk("fall", evt[i][1] & !(b[i] > t) & (a[i] > t), res[i].fall_evt);
         end
      end
      @(posedge clk);
      #1;
      for (int i = 0; i < 26; i++) chk("pulse", 2'h0, {res[i].rise_evt, res[i].fall_evt});
   endtask : trial

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial begin
      logic [5:0]  a;
      logic [23:0] d;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int r = 0; r < 6; r++) begin
         readback();
         trial();
         for (int w = 0; w < 8; w++) begin
            a = 6'(32'h2B + nxt() % 7);
            d = 24'(nxt());
            host_u.wr(a, d);
            if (msk(a) != 0) sh[a-6'h2C] = d & msk(a);
         end
      end
      readback();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule : switch_threshold_config_bank_tb
